// >>> fwph_device.sv
// Device end: command gating, sector protection and hold pause
`timescale 1ns/100ps
// What this block does
// - Modifying frames need whole bytes of clocks
// - Modifying instructions need the write permit latch
// - Listed instructions and power-up clear permit latch
// - Deep sleep ignores write, program and erase
// - Each 64 Kbyte sector has a lock register
// - Write lock set makes sector changes fail
// - Lock down freezes lock bits until power-up
// - Extent bits protect top sectors when high-end
// - Extent bits protect bottom sectors when low-end
// - Write-protect pin freezes extent and freeze bits
// - Hold never aborts a running internal cycle
// - Hold pause only while chip is selected
// - Pause starts at hold fall with clock low
// - Pause ends at hold rise with clock low
// - Paused: output floats, clock and input ignored
// - Master keeps select low during the pause
// - Deselect in pause resets link; hold first
// - Power-up delay blocks modifying operations
// - Input on rising clock, output on falling
module fwph_device
	import fwph_pkg::*;
#(
	parameter int unsigned PUW_CYCLES = PUW_CYC
)
(
	// Clock and reset
	input  logic       mclk,
	input  logic       rst,
	// Serial link
	fwph_if.dev        lk,
	// Status
	output logic       write_permit_latch,
	output logic       busy,
	output logic       sleep,
	output logic [2:0] extent,
	output logic       low_end,
	output logic       freeze,
	// Events
	output logic       exec,
	output logic [7:0] exec_op,
	output logic       refuse
);
	// =========================================================
	// Link clock domain
	logic       first_q;
	logic       hold_q;
	logic [2:0] bitc_q;
	logic [2:0] nb_q;
	logic [7:0] sh_q;
	logic [7:0] op_q;
	logic [7:0] b1_q;
	logic [7:0] b4_q;
	logic [7:0] out_q;
	logic       oe_q;
	logic [7:0] stat_byte;
	logic [7:0] lock_byte;

	// Main clock domain state, read quasi-statically by the link side
	logic               wel_q;
	logic               busy_q;
	logic               sleep_q;
	logic [2:0]         ext_q;
	logic               low_q;
	logic               frz_q;
	logic [SECTORS-1:0] wl_q;
	logic [SECTORS-1:0] ld_q;

	wire [7:0] sh_d   = {sh_q[6:0], lk.si};
	wire [2:0] bitc_d = first_q ? 3'h1 : bitc_q + 3'h1;
	wire       byte_d = ~first_q & (bitc_d == 3'h0);
	wire [SEC_W-1:0] rd_sec = b1_q[SEC_W-1:0];
	wire rd_stat = (op_q == OP_STAT_FETCH) && (nb_q != 3'h0);
	wire rd_lock = (op_q == OP_LOCK_FETCH) && (nb_q >= BYTE_DATA);
	// Hold takes effect at once while the clock is low
	wire hold_eff = lk.sclk ? hold_q : ~lk.hold_n;

	assign lk.so    = out_q[7];
	assign lk.so_oe = oe_q & ~hold_eff;

	always_comb
	begin
		stat_byte = 8'h00;
		stat_byte[ST_WIP] = busy_q;
		stat_byte[ST_WEL] = wel_q;
		stat_byte[ST_EXT +: 3] = ext_q;
		stat_byte[ST_LOW] = low_q;
		stat_byte[ST_FRZ] = frz_q;
		lock_byte = 8'h00;
		lock_byte[LK_WL] = wl_q[rd_sec];
		lock_byte[LK_LD] = ld_q[rd_sec];
	end

	// Deselect restarts the frame, also out of a pause
	always_ff @(posedge lk.sclk or posedge lk.cs_n)
	begin
		if (lk.cs_n)
			first_q <= 1'b1;
		else if (lk.hold_n)
			first_q <= 1'b0;
	end

	// Input bits are taken on the rising clock
	always_ff @(posedge lk.sclk)
	begin
		// Hold low at a rising edge means paused: the clock was low before
		if (lk.hold_n)
		begin
			sh_q   <= sh_d;
			bitc_q <= bitc_d;
			if (first_q)
				nb_q <= 3'h0;
			else if (byte_d && nb_q != 3'h7)
				nb_q <= nb_q + 3'h1;
			if (byte_d && nb_q == 3'h0)
				op_q <= sh_d;
			if (byte_d && nb_q == BYTE_SEC)
				b1_q <= sh_d;
			if (byte_d && nb_q == BYTE_DATA)
				b4_q <= sh_d;
		end
	end

	// Output bits change on the falling clock
	always_ff @(negedge lk.sclk or posedge lk.cs_n)
	begin
		if (lk.cs_n)
		begin
			hold_q <= 1'b0;
			out_q  <= 8'h00;
			oe_q   <= 1'b0;
		end
		else
		begin
			hold_q <= ~lk.hold_n;
			if (lk.hold_n && !first_q)
			begin
				if (bitc_q == 3'h0)
				begin
					out_q <= rd_lock ? lock_byte : stat_byte;
					oe_q  <= rd_stat | rd_lock;
				end
				else
					out_q <= {out_q[6:0], 1'b0};
			end
		end
	end

	// =========================================================
	// Main clock domain: pin synchronisers
	logic [2:0]  cs_sq;
	logic [1:0]  first_sq;
	logic [1:0]  hold_sq;
	logic [1:0]  wp_sq;
	logic        seen_q;
	logic [15:0] busy_cnt_q;
	logic [31:0] puw_cnt_q;
	logic        puw_q;
	logic        exec_q;
	logic [7:0]  exec_op_q;
	logic        refuse_q;
	logic [SECTORS-1:0] prot;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cs_sq    <= 3'h7;
			first_sq <= 2'h3;
			hold_sq  <= 2'h3;
			wp_sq    <= 2'h3;
		end
		else
		begin
			cs_sq    <= {cs_sq[1:0], lk.cs_n};
			first_sq <= {first_sq[0], first_q};
			hold_sq  <= {hold_sq[0], lk.hold_n};
			wp_sq    <= {wp_sq[0], lk.wp_n};
		end
	end

	// =========================================================
	// Command decode at the end of a frame
	wire frame_end = cs_sq[1] & ~cs_sq[2];
	// Deselect during a pause discards the frame
	wire take = frame_end & seen_q & hold_sq[1];
	wire aligned = (bitc_q == 3'h0) && (nb_q != 3'h0);
	wire [SEC_W-1:0] sec = b1_q[SEC_W-1:0];
	wire is_prog = (op_q == OP_PAGE_WR) || (op_q == OP_DUAL_WR)
		|| (op_q == OP_WIPE_4K) || (op_q == OP_WIPE_64K);
	wire is_mod = is_prog || (op_q == OP_STAT_STORE)
		|| (op_q == OP_LOCK_STORE) || (op_q == OP_OTP_STORE)
		|| (op_q == OP_WIPE_ALL);
	wire live = take & aligned & ~busy_q & ~sleep_q;
	wire may_mod = live & is_mod & wel_q & ~puw_q;
	wire frozen = frz_q & ~wp_sq[1];
	wire st_wr = may_mod & (op_q == OP_STAT_STORE);
	wire st_ok = st_wr & ~frozen;
	wire lk_wr = may_mod & (op_q == OP_LOCK_STORE) & ~ld_q[sec];
	wire prog_ok = may_mod & is_prog & ~prot[sec];
	wire all_ok = may_mod & (op_q == OP_WIPE_ALL)
		& (ext_q == 3'h0) & ~|wl_q;
	wire otp_ok = may_mod & (op_q == OP_OTP_STORE);
	wire start = st_ok | prog_ok | all_ok | otp_ok;
	wire wel_clr = live & ((op_q == OP_CLEAR) | is_mod);
	wire wel_set = live & (op_q == OP_PERMIT);

	fwph_guard u_guard
	(
		.extent  (ext_q),
		.low_end (low_q),
		.wlock   (wl_q),
		.prot    (prot)
	);

	always_ff @(posedge mclk)
	begin
		if (rst || frame_end)
			seen_q <= 1'b0;
		else if (!cs_sq[1] && !first_sq[1])
			seen_q <= 1'b1;
	end

	// Power-up delay, then internal cycle timer
	always_ff @(posedge mclk)
	begin
		if (rst)
			puw_cnt_q <= 32'h0;
		else if (puw_q)
			puw_cnt_q <= puw_cnt_q + 32'h1;
	end
	assign puw_q = puw_cnt_q < PUW_CYCLES;

	// The cycle runs on the main clock, whatever the link does
	always_ff @(posedge mclk)
	begin
		if (rst)
			busy_cnt_q <= 16'h0;
		else if (start)
			busy_cnt_q <= BUSY_CYC;
		else if (busy_cnt_q != 16'h0)
			busy_cnt_q <= busy_cnt_q - 16'h1;
	end
	assign busy_q = busy_cnt_q != 16'h0;

	always_ff @(posedge mclk)
	begin
		if (rst || wel_clr)
			wel_q <= 1'b0;
		else if (wel_set)
			wel_q <= 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			sleep_q <= 1'b0;
		else if (take && aligned && !busy_q && op_q == OP_SLEEP)
			sleep_q <= 1'b1;
		else if (take && aligned && op_q == OP_WAKE)
			sleep_q <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ext_q <= EXT_RST;
			low_q <= LOW_RST;
			frz_q <= FRZ_RST;
		end
		else if (st_ok)
		begin
			ext_q <= b1_q[ST_EXT +: 3];
			low_q <= b1_q[ST_LOW];
			frz_q <= b1_q[ST_FRZ];
		end
	end

	for (genvar i = 0; i < SECTORS; i++)
	begin : g_lock
		always_ff @(posedge mclk)
		begin
			if (rst)
			begin
				wl_q[i] <= 1'b0;
				ld_q[i] <= 1'b0;
			end
			else if (lk_wr && sec == SEC_W'(i))
			begin
				wl_q[i] <= b4_q[LK_WL];
				ld_q[i] <= b4_q[LK_LD];
			end
		end
	end

	// =========================================================
	// User-side outputs
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			exec_q    <= 1'b0;
			exec_op_q <= 8'h00;
			refuse_q  <= 1'b0;
		end
		else
		begin
			exec_q   <= start | lk_wr;
			refuse_q <= take & is_mod & ~(start | lk_wr);
			if (take)
				exec_op_q <= op_q;
		end
	end

	assign write_permit_latch     = wel_q;
	assign busy    = busy_q;
	assign sleep   = sleep_q;
	assign extent  = ext_q;
	assign low_end = low_q;
	assign freeze  = frz_q;
	assign exec    = exec_q;
	assign exec_op = exec_op_q;
	assign refuse  = refuse_q;
endmodule

// >>> fwph_guard.sv
// Per-sector protection map from range bits and write lock bits
`timescale 1ns/100ps
module fwph_guard
	import fwph_pkg::*;
(
	// Range protection setting
	input  logic [2:0]         extent,
	input  logic               low_end,
	// Per-sector write locks
	input  logic [SECTORS-1:0] wlock,
	// Result
	output logic [SECTORS-1:0] prot
);
	logic [5:0] span;

	always_comb
	begin
		unique case (extent)
			3'h0: span = 6'h00;
			3'h1: span = 6'h01;
			3'h2: span = 6'h02;
			3'h3: span = 6'h04;
			3'h4: span = 6'h08;
			3'h5: span = 6'h10;
			3'h6: span = 6'h20;
			3'h7: span = 6'h20;
		endcase
	end

	for (genvar i = 0; i < SECTORS; i++)
	begin : g_sec
		wire top_hit = 6'(i) >= (6'h20 - span);
		wire low_hit = 6'(i) < span;
		assign prot[i] = wlock[i] | (low_end ? low_hit : top_hit);
	end
endmodule

// >>> fwph_host.sv
// Master end: frames bytes on the serial link, with hold pauses
`timescale 1ns/100ps
module fwph_host
	import fwph_pkg::*;
(
	// Clock and reset
	input  logic        mclk,
	input  logic        rst,
	// Serial link
	fwph_if.host        lk,
	// Request
	input  logic        go,
	input  logic [39:0] tx_bytes,
	input  logic [2:0]  n_bytes,
	input  logic        pause,
	input  logic        wp_level,
	// Answer
	output logic        busy,
	output logic        done,
	output logic [7:0]  rx_byte
);
	fwph_hst_e   st_q;
	logic [3:0]  div_q;
	logic [5:0]  bits_q;
	logic [39:0] tx_q;
	logic [7:0]  rx_q;
	logic        sclk_q;
	logic        cs_n_q;
	logic        hold_n_q;
	logic        si_q;
	logic        wp_n_q;
	logic        busy_q;
	logic        done_q;
	logic [1:0]  so_sq;

	wire tick = div_q == (HALF_DIV - 4'h1);

	// =========================================================
	// Half-period divider and data-out synchroniser
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			div_q <= 4'h0;
			so_sq <= 2'h0;
		end
		else
		begin
			div_q <= tick ? 4'h0 : div_q + 4'h1;
			so_sq <= {so_sq[0], lk.so};
		end
	end

	// =========================================================
	// Frame sequencer
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_q     <= H_IDLE;
			bits_q   <= 6'h00;
			tx_q     <= 40'h0;
			rx_q     <= 8'h00;
			sclk_q   <= 1'b0;
			cs_n_q   <= 1'b1;
			hold_n_q <= 1'b1;
			si_q     <= 1'b0;
			wp_n_q   <= 1'b1;
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			wp_n_q <= ~wp_level;
			unique case (st_q)
				H_IDLE:
					if (go)
					begin
						tx_q   <= tx_bytes;
						bits_q <= {n_bytes, 3'h0};
						si_q   <= tx_bytes[39];
						cs_n_q <= 1'b0;
						busy_q <= 1'b1;
						st_q   <= (n_bytes == 3'h0) ? H_TAIL : H_LEAD;
					end
				H_LEAD:
					if (tick)
					begin
						sclk_q <= 1'b1;
						st_q   <= H_HIGH;
					end
				H_HIGH:
					if (tick)
					begin
						sclk_q <= 1'b0;
						rx_q   <= {rx_q[6:0], so_sq[1]};
						tx_q   <= {tx_q[38:0], 1'b0};
						bits_q <= bits_q - 6'h01;
						si_q   <= tx_q[38];
						st_q   <= (bits_q == 6'h01) ? H_TAIL : H_LOW;
					end
				H_LOW:
					if (tick && pause)
					begin
						hold_n_q <= 1'b0;
						st_q     <= H_PAUSE;
					end
					else if (tick)
					begin
						sclk_q <= 1'b1;
						st_q   <= H_HIGH;
					end
				H_PAUSE:
					// Select stays low for the whole pause
					if (tick && !pause)
					begin
						hold_n_q <= 1'b1;
						st_q     <= H_LOW;
					end
				H_TAIL:
					if (tick)
					begin
						cs_n_q <= 1'b1;
						st_q   <= H_GAP;
					end
				H_GAP:
					if (tick)
					begin
						busy_q <= 1'b0;
						done_q <= 1'b1;
						st_q   <= H_IDLE;
					end
			endcase
		end
	end

	assign lk.sclk   = sclk_q;
	assign lk.cs_n   = cs_n_q;
	assign lk.hold_n = hold_n_q;
	assign lk.si     = si_q;
	assign lk.wp_n   = wp_n_q;
	assign busy      = busy_q;
	assign done      = done_q;
	assign rx_byte   = rx_q;
endmodule

// >>> fwph_if.sv
// Serial link between the flash device and its bus master
`timescale 1ns/100ps
interface fwph_if;
	logic sclk;
	logic cs_n;
	logic hold_n;
	logic wp_n;
	logic si;
	logic so;
	logic so_oe;

	modport dev
	(
		input  sclk,
		input  cs_n,
		input  hold_n,
		input  wp_n,
		input  si,
		output so,
		output so_oe
	);

	modport host
	(
		output sclk,
		output cs_n,
		output hold_n,
		output wp_n,
		output si,
		input  so,
		input  so_oe
	);
endinterface

// >>> fwph_pkg.sv
// Shared constants and types of the flash write-protect and hold block
package fwph_pkg;

	// =========================================================
	// Instruction codes (arbitrary values)
	localparam logic [7:0] OP_PERMIT     = 8'h16;
	localparam logic [7:0] OP_CLEAR      = 8'h14;
	localparam logic [7:0] OP_STAT_FETCH = 8'h15;
	localparam logic [7:0] OP_STAT_STORE = 8'h11;
	localparam logic [7:0] OP_LOCK_FETCH = 8'h38;
	localparam logic [7:0] OP_LOCK_STORE = 8'h35;
	localparam logic [7:0] OP_OTP_STORE  = 8'h52;
	localparam logic [7:0] OP_PAGE_WR    = 8'h12;
	localparam logic [7:0] OP_DUAL_WR    = 8'h1A;
	localparam logic [7:0] OP_WIPE_4K    = 8'h30;
	localparam logic [7:0] OP_WIPE_64K   = 8'hD0;
	localparam logic [7:0] OP_WIPE_ALL   = 8'hC0;
	localparam logic [7:0] OP_SLEEP      = 8'hB0;
	localparam logic [7:0] OP_WAKE       = 8'hA0;

	// =========================================================
	// Status byte layout and reset values
	localparam int         ST_WIP  = 0;
	localparam int         ST_WEL  = 1;
	localparam int         ST_EXT  = 2;
	localparam int         ST_LOW  = 5;
	localparam int         ST_FRZ  = 7;
	localparam logic [2:0] EXT_RST = 3'h0;
	localparam logic       LOW_RST = 1'b0;
	localparam logic       FRZ_RST = 1'b0;

	// =========================================================
	// Lock byte layout and frame byte positions
	localparam int         LK_WL     = 0;
	localparam int         LK_LD     = 1;
	localparam logic [2:0] BYTE_SEC  = 3'h1;
	localparam logic [2:0] BYTE_DATA = 3'h4;
	localparam int         SECTORS   = 32;
	localparam int         SEC_W     = 5;

	// =========================================================
	// Timing
	localparam int          MCLK_MHZ = 100;
	localparam int          BUSY_NS  = 2000;
	localparam logic [15:0] BUSY_CYC =
		16'((BUSY_NS * MCLK_MHZ + 999) / 1000);
	localparam int          PUW_US   = 1000;
	localparam int          PUW_CYC  = PUW_US * MCLK_MHZ;
	localparam logic [3:0]  HALF_DIV = 4'h4;

	// =========================================================
	// Master sequencer states
	typedef enum logic [2:0]
	{
		H_IDLE,
		H_LEAD,
		H_LOW,
		H_HIGH,
		H_PAUSE,
		H_TAIL,
		H_GAP
	} fwph_hst_e;

endpackage

// >>> fwph_properties.sv
// Link and status checks of the flash write-protect and hold pair
`timescale 1ns/100ps
module fwph_properties
	import fwph_pkg::*;
#(
	parameter int unsigned PUW_CYCLES = PUW_CYC
)
(
	// Clock and reset
	input logic       mclk,
	input logic       rst,
	// Link
	input logic       sclk,
	input logic       cs_n,
	input logic       hold_n,
	input logic       wp_n,
	input logic       so_oe,
	// Device status
	input logic       write_permit_latch,
	input logic       busy,
	input logic       sleep,
	input logic [2:0] extent,
	input logic       low_end,
	input logic       freeze,
	input logic       exec,
	input logic [7:0] exec_op
);
	// ========================================
	// Helpers: time since reset, busy length
	logic        mod_op;
	logic [31:0] up_q;
	logic [15:0] bz_q;

	assign mod_op = exec_op inside {OP_STAT_STORE, OP_LOCK_STORE,
		OP_OTP_STORE, OP_PAGE_WR, OP_DUAL_WR, OP_WIPE_4K, OP_WIPE_64K,
		OP_WIPE_ALL};

	always_ff @(posedge mclk)
	begin
		up_q <= rst ? 32'h0 : up_q + 32'(up_q < PUW_CYCLES);
		bz_q <= busy ? bz_q + 16'h1 : 16'h0;
	end

	// ========================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_deselect_floats: assert property (
		cs_n && $past(cs_n) && $past(cs_n, 2) |-> !so_oe)
		else $error("so driven while deselected");
	a_pause_floats: assert property (
		(!hold_n && !sclk && !cs_n)[*4] |-> !so_oe)
		else $error("so driven during hold pause");
	a_permit_first: assert property (
		exec && mod_op |-> $past(write_permit_latch, 2) || $past(write_permit_latch, 3) || $past(write_permit_latch, 4))
		else $error("modifying command taken without permit");
	a_permit_cleared: assert property (
		exec && mod_op |-> ##[0:3] !write_permit_latch)
		else $error("permit latch not cleared");
	a_sleep_blocks: assert property (
		exec && mod_op |-> !$past(sleep, 2))
		else $error("modifying command taken in deep sleep");
	a_powerup_wait: assert property (
		exec && mod_op |-> up_q >= PUW_CYCLES)
		else $error("modifying command taken during power-up delay");
	a_wipe_range: assert property (
		exec && exec_op == OP_WIPE_ALL |-> extent == 3'h0)
		else $error("full wipe taken with range protection");
	a_frozen_status: assert property (
		!wp_n && freeze |=> $stable({extent, low_end, freeze}))
		else $error("frozen status changed");
	a_busy_length: assert property (
		$fell(busy) |-> bz_q >= 16'd198 && bz_q <= 16'd202)
		else $error("internal cycle cut short or stretched");

	c_exec: cover property (exec && mod_op);
	c_pause: cover property (!hold_n && !cs_n && !sclk);
	c_frozen: cover property (!wp_n && freeze);
endmodule

// >>> test_flash_write_protect_and_hold.sv
// Self-checking bench of the flash device joined to its bus master
`timescale 1ns/100ps
module test_flash_write_protect_and_hold
	import fwph_pkg::*;
;
	// ========================================
	// Signals
	logic        mclk;
	logic        rst;
	logic        go;
	logic        pause;
	logic        wp_level;
	logic [39:0] tx;
	logic [2:0]  nb;
	logic        done;
	logic [7:0]  rx;
	logic        write_permit_latch;
	logic        d_busy;
	logic        sleep;
	logic [2:0]  extent;
	logic        low_end;
	logic        freeze;
	logic        exec;
	logic [7:0]  exec_op;
	logic        saw_x;
	logic        refuse;
	logic        saw_r;
	int          errors;
	int          total_checks;

	fwph_if lk ();

	fwph_device #(.PUW_CYCLES(600)) u_fwph_device
	(
		.mclk(mclk), .rst(rst), .lk(lk.dev), .write_permit_latch(write_permit_latch), .busy(d_busy),
		.sleep(sleep), .extent(extent), .low_end(low_end),
		.freeze(freeze), .exec(exec), .exec_op(exec_op), .refuse(refuse)
	);
	fwph_host u_fwph_host
	(
		.mclk(mclk), .rst(rst), .lk(lk.host), .go(go), .tx_bytes(tx),
		.n_bytes(nb), .pause(pause), .wp_level(wp_level), .busy(),
		.done(done), .rx_byte(rx)
	);
	fwph_properties #(.PUW_CYCLES(600)) u_fwph_properties
	(
		.mclk(mclk), .rst(rst), .sclk(lk.sclk), .cs_n(lk.cs_n),
		.hold_n(lk.hold_n), .wp_n(lk.wp_n), .so_oe(lk.so_oe),
		.write_permit_latch(write_permit_latch), .busy(d_busy), .sleep(sleep), .extent(extent),
		.low_end(low_end), .freeze(freeze), .exec(exec),
		.exec_op(exec_op)
	);

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
		if (exec === 1'b1)
			saw_x <= 1'b1;

	always @(posedge mclk)
		if (refuse === 1'b1)
			saw_r <= 1'b1;

	// ========================================
	// Shared tasks
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic xfer(logic [39:0] b, logic [2:0] n, int hp);
		int k;
		@(negedge mclk);
		tx = b;
		nb = n;
		go = 1'b1;
		saw_x = 1'b0;
		saw_r = 1'b0;
		@(negedge mclk);
		go = 1'b0;
		if (hp > 0)
		begin
			repeat (30) @(negedge mclk);
			pause = 1'b1;
			repeat (hp) @(negedge mclk);
			pause = 1'b0;
		end
		for (k = 0; k < 3000 && done !== 1'b1; k++)
			@(negedge mclk);
		chk("done", 8'h1, {7'h0, done});
		repeat (12) @(negedge mclk);
	endtask

	task automatic op(logic [7:0] c, logic [7:0] s, logic [7:0] d);
		int k;
		xfer({c, s, 16'h0, d}, 3'h5, 0);
		for (k = 0; k < 300 && d_busy !== 1'b0; k++)
			@(negedge mclk);
	endtask

	task automatic pm();
		xfer({OP_PERMIT, 32'h0}, 3'h1, 0);
	endtask

	task automatic probe(int s, logic ex);
		pm();
		op(OP_PAGE_WR, 8'(s), 8'h0);
		chk("range", {7'h0, ex}, {7'h0, saw_x});
	endtask

	// ========================================
	// Scenarios
	task automatic t_power();
		pm();
		chk("wel", 8'h1, {7'h0, write_permit_latch});
		op(OP_PAGE_WR, 8'h03, 8'h0);
		chk("early", 8'h0, {7'h0, saw_x});
		repeat (200) @(negedge mclk);
		$display("t_power end");
	endtask

	task automatic t_permit();
		logic [7:0] ops [9] = '{OP_CLEAR, OP_STAT_STORE, OP_LOCK_STORE,
			OP_OTP_STORE, OP_PAGE_WR, OP_DUAL_WR, OP_WIPE_4K,
			OP_WIPE_64K, OP_WIPE_ALL};
		xfer({OP_CLEAR, 32'h0}, 3'h1, 0);
		op(OP_PAGE_WR, 8'h03, 8'h0);
		chk("nowel", 8'h0, {7'h0, saw_x});
		foreach (ops[i])
		begin
			pm();
			chk("wel", 8'h1, {7'h0, write_permit_latch});
			op(ops[i], 8'h03, 8'h0);
			chk("exec", {7'h0, i != 0}, {7'h0, saw_x});
			chk("clr", 8'h0, {7'h0, write_permit_latch});
		end
		$display("t_permit end");
	endtask

	task automatic t_range();
		int n;
		for (int lo = 0; lo < 2; lo++)
			for (int e = 0; e < 8; e++)
			begin
				n = (e == 0) ? 0 : (e > 5) ? 32 : 1 << (e - 1);
				pm();
				op(OP_STAT_STORE, 8'((lo << 5) | (e << 2)), 8'h0);
				chk("ext", 8'(e), {5'h0, extent});
				chk("low", 8'(lo), {7'h0, low_end});
				if (n > 0)
					probe(lo ? n - 1 : 32 - n, 1'b0);
				if (n < 32)
					probe(lo ? n : 31 - n, 1'b1);
			end
		pm();
		op(OP_STAT_STORE, 8'h0, 8'h0);
		$display("t_range end");
	endtask

	task automatic t_freeze();
		pm();
		op(OP_STAT_STORE, 8'h84, 8'h0);
		pm();
		op(OP_WIPE_ALL, 8'h0, 8'h0);
		chk("wipe", 8'h0, {7'h0, saw_x});
		wp_level = 1'b1;
		pm();
		op(OP_STAT_STORE, 8'h00, 8'h0);
		chk("frz", 8'h81, {freeze, 4'h0, extent});
		chk("frzref", 8'h1, {7'h0, saw_r});
		wp_level = 1'b0;
		pm();
		op(OP_STAT_STORE, 8'h00, 8'h0);
		chk("thaw", 8'h00, {freeze, 4'h0, extent});
		$display("t_freeze end");
	endtask

	task automatic t_hold();
		pm();
		xfer({OP_PAGE_WR, 8'h09, 24'h0}, 3'h5, 60);
		chk("held", 8'h1, {7'h0, saw_x});
		xfer({OP_STAT_FETCH, 32'h0}, 3'h2, 10);
		chk("wip", 8'h1, {7'h0, rx[ST_WIP]});
		op(OP_CLEAR, 8'h0, 8'h0);
		$display("t_hold end");
	endtask

	task automatic t_sleep();
		pm();
		xfer({OP_SLEEP, 32'h0}, 3'h1, 0);
		op(OP_PAGE_WR, 8'h09, 8'h0);
		chk("slp", 8'h2, {6'h0, sleep, saw_x});
		chk("wel", 8'h1, {7'h0, write_permit_latch});
		xfer({OP_WAKE, 32'h0}, 3'h1, 0);
		chk("wake", 8'h0, {7'h0, sleep});
		$display("t_sleep end");
	endtask

	task automatic t_lock();
		pm();
		op(OP_LOCK_STORE, 8'h05, 8'h01);
		xfer({OP_LOCK_FETCH, 8'h05, 24'h0}, 3'h5, 0);
		chk("lock", 8'h01, rx);
		pm();
		op(OP_PAGE_WR, 8'h05, 8'h0);
		chk("locked", 8'h0, {7'h0, saw_x});
		pm();
		op(OP_PAGE_WR, 8'h06, 8'h0);
		chk("free", 8'h1, {7'h0, saw_x});
		pm();
		op(OP_LOCK_STORE, 8'h05, 8'h03);
		pm();
		op(OP_LOCK_STORE, 8'h05, 8'h00);
		chk("down", 8'h0, {7'h0, saw_x});
		chk("refuse", 8'h1, {7'h0, saw_r});
		xfer({OP_LOCK_FETCH, 8'h05, 24'h0}, 3'h5, 0);
		chk("lock", 8'h03, rx);
		$display("t_lock end");
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ========================================
	// Main sequence and watchdog
	initial
	begin
		errors = 0;
		total_checks = 0;
		rst = 1'b1;
		go = 1'b0;
		pause = 1'b0;
		wp_level = 1'b0;
		tx = 40'h0;
		nb = 3'h0;
		saw_x = 1'b0;
		saw_r = 1'b0;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		t_power();
		t_permit();
		t_range();
		t_freeze();
		t_hold();
		t_sleep();
		t_lock();
		wrap_up();
	end

	initial
	begin
		#1000000;
		errors++;
		$display("BAD watchdog exp finish got hang");
		wrap_up();
	end
endmodule
